/* File: pkg/cie_pkg.sv */
// Purpose: constants for the interrupt and exception entry unit
// Assumes: 32-bit data, AXI4-Lite register port, single clock
// Notes: event codes and vector offsets are fixed by the core
package cie_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_VBR = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_SPC = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_SSR = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_SGR = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_INTERRUPT_EVENT_CODE = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_EXCEPTION_EVENT_CODE = 8'h1C;
  // Control register fields
  localparam int CTRL_NMI_BLOCK_ACCEPT = 0;
  // Status word fields
  localparam int SR_IMASK_LO = 4;
  localparam int SR_BL = 28;
  localparam int SR_RB = 29;
  localparam int SR_MD = 30;
  localparam logic [DATA_W-1:0] SR_RESET = 32'h700000F0;
  // Event codes and vector offsets
  localparam logic [DATA_W-1:0] CODE_NMI = 32'h000001C0;
  localparam logic [DATA_W-1:0] CODE_IRL_BASE = 32'h00000200;
  localparam logic [DATA_W-1:0] CODE_IRL_STEP = 32'h00000020;
  localparam logic [DATA_W-1:0] CODE_MOD_MIN = 32'h00000400;
  localparam logic [DATA_W-1:0] CODE_MOD_MAX = 32'h00000B80;
  localparam logic [DATA_W-1:0] CODE_MANUAL_RESET = 32'h00000020;
  localparam logic [DATA_W-1:0] VEC_INTERRUPT = 32'h00000600;
  localparam logic [DATA_W-1:0] VEC_GENERAL = 32'h00000100;
  localparam logic [DATA_W-1:0] RESET_PC = 32'hA0000000;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Exception sources in the double-access order
  typedef enum logic [2:0] {
    CIE_EXC_ADDR_ERR = 3'h0,
    CIE_EXC_TLB_MISS = 3'h1,
    CIE_EXC_PROT = 3'h2,
    CIE_EXC_INIT_WR = 3'h3,
    CIE_EXC_NONE = 3'h7
  } cie_exc_t;
endpackage

/* File: src/cie_prio.sv */
// Purpose: ranks pipeline exceptions of one instruction or branch pair
// Assumes: flags are valid in the cycle they are offered
// Notes: purely combinational
module cie_prio
  import cie_pkg::*;
(
  // Double access flags, per transfer: addr err, tlb miss, prot, init write
  input wire logic [3:0] first_xfer,
  input wire logic [3:0] second_xfer,
  // Pair flags, bit 0 branch, bit 1 slot
  input wire logic [1:0] reexec_l12,
  input wire logic [1:0] compl_l2,
  input wire logic [1:0] lvl3,
  input wire logic [1:0] lvl4,
  // Result
  output logic hit,
  output logic hit_slot,
  output logic hit_reexec,
  output logic hit_second,
  output cie_exc_t hit_kind
);
  import cie_pkg::*;
  always_comb begin
    hit = 1'b1;
    hit_slot = 1'b0;
    hit_reexec = 1'b1;
    hit_second = 1'b0;
    hit_kind = CIE_EXC_NONE;
    if (reexec_l12[0]) begin
      hit_slot = 1'b0;
    end else if (reexec_l12[1] || (|first_xfer) || (|second_xfer)) begin
      hit_slot = 1'b1;
      if (first_xfer[0]) hit_kind = CIE_EXC_ADDR_ERR;
      else if (first_xfer[1]) hit_kind = CIE_EXC_TLB_MISS;
      else if (first_xfer[2]) hit_kind = CIE_EXC_PROT;
      else if (first_xfer[3]) hit_kind = CIE_EXC_INIT_WR;
      else if (second_xfer[0]) begin
        hit_kind = CIE_EXC_ADDR_ERR;
        hit_second = 1'b1;
      end else if (second_xfer[1]) begin
        hit_kind = CIE_EXC_TLB_MISS;
        hit_second = 1'b1;
      end else if (second_xfer[2]) begin
        hit_kind = CIE_EXC_PROT;
        hit_second = 1'b1;
      end else if (second_xfer[3]) begin
        hit_kind = CIE_EXC_INIT_WR;
        hit_second = 1'b1;
      end
    end else if (compl_l2[0]) begin
      hit_reexec = 1'b0;
    end else if (compl_l2[1]) begin
      hit_reexec = 1'b0;
      hit_slot = 1'b1;
    end else if ((|lvl3) || (|lvl4)) begin
      hit_reexec = 1'b0;
    end else begin
      hit = 1'b0;
      hit_reexec = 1'b0;
    end
  end
endmodule

/* File: src/cie_top.sv */
// Purpose: interrupt and exception entry for the core
// Assumes: pipeline offers one boundary event per cycle at most
// Notes: registers over AXI4-Lite, redirect, manual_reset and pr_write_block are pulses
//
// Decided for this implementation: register access over AXI4-Lite and the address map.

// Notes on behaviour
// - NMI acceptance writes code 1C0
// - Entry saves return PC, status, stack
// - Entry sets BL MD RB, vectors 600 for irq, 100 for exception
// - NMI ignores mask, top priority
// - Control bit decides NMI under BL
// - Level irq needs BL clear, mask below
// - Level irq codes 200 to 3C0
// - Mask bits untouched on acceptance
// - Module irq code 400 to B80
// - Double access exception order fixed
// - Branch pair checked as one
// - Slot second transfer checked twice
// - Slot reexec blocks return address write
// - Return restores PC and status
// - Non-break exception under BL gives manual reset
// - Ordinary irq pends while BL set
// - Sleep accepts irq despite BL
// - Reexec saves faulting or slot PC
// - Completion saves next or destination
module cie_top
  import cie_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [cie_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [cie_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [cie_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [cie_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt controller
  input wire logic nmi_pin,
  input wire logic [3:0] encoded_irq_level,
  input wire logic mod_irq_req,
  input wire logic [3:0] mod_irq_level,
  input wire logic [cie_pkg::DATA_W-1:0] mod_irq_code,
  // Pipeline
  input wire logic boundary,
  input wire logic sleeping,
  input wire logic [cie_pkg::DATA_W-1:0] cur_pc,
  input wire logic [cie_pkg::DATA_W-1:0] next_pc,
  input wire logic [cie_pkg::DATA_W-1:0] branch_dest,
  input wire logic [cie_pkg::DATA_W-1:0] slot_pc,
  input wire logic in_branch_pair,
  input wire logic [cie_pkg::DATA_W-1:0] stack_gpr,
  input wire logic [3:0] first_xfer,
  input wire logic [3:0] second_xfer,
  input wire logic [1:0] reexec_l12,
  input wire logic [1:0] compl_l2,
  input wire logic [1:0] lvl3,
  input wire logic [1:0] lvl4,
  input wire logic [cie_pkg::DATA_W-1:0] exc_code,
  input wire logic user_break,
  input wire logic rte_exec,
  // Entry outputs
  output logic redirect,
  output logic [cie_pkg::DATA_W-1:0] redirect_pc,
  output logic manual_reset,
  output logic pr_write_block,
  output logic [cie_pkg::DATA_W-1:0] saved_r15,
  output logic [cie_pkg::DATA_W-1:0] status_word
);
  import cie_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [DATA_W-1:0] sr_r;
  logic [DATA_W-1:0] vector_base_r;
  logic [DATA_W-1:0] saved_pc_r;
  logic [DATA_W-1:0] saved_status_r;
  logic [DATA_W-1:0] saved_r15_r;
  logic [DATA_W-1:0] interrupt_event_code_r;
  logic [DATA_W-1:0] exception_event_code_r;
  logic ctrl_nmi_accept_r;
  logic nmi_prev_r;
  logic nmi_pend_r;
  logic redirect_r;
  logic [DATA_W-1:0] redirect_pc_r;
  logic manual_reset_r;
  logic pr_block_r;

  // ----------------------------------------
  // Exception ranking
  // ----------------------------------------
  logic exc_hit;
  logic exc_slot;
  logic exc_reexec;
  logic exc_second;
  cie_exc_t exc_kind;

  cie_prio u_prio (
    .first_xfer(first_xfer),
    .second_xfer(second_xfer),
    .reexec_l12(reexec_l12),
    .compl_l2(compl_l2),
    .lvl3(lvl3),
    .lvl4(lvl4),
    .hit(exc_hit),
    .hit_slot(exc_slot),
    .hit_reexec(exc_reexec),
    .hit_second(exc_second),
    .hit_kind(exc_kind)
  );

  // ----------------------------------------
  // Acceptance
  // ----------------------------------------
  logic bl;
  logic [3:0] imask;
  logic nmi_edge;
  logic nmi_live;
  logic open_gate;
  logic take_nmi;
  logic take_irl;
  logic take_mod;
  logic take_int;
  logic take_exc;
  logic take_mreset;
  logic [DATA_W-1:0] int_code;
  logic [DATA_W-1:0] save_pc;
  logic [DATA_W-1:0] mod_code_clip;

  assign bl = sr_r[SR_BL];
  assign imask = sr_r[SR_IMASK_LO +: 4];
  assign nmi_edge = nmi_pin && !nmi_prev_r;
  assign nmi_live = nmi_edge || nmi_pend_r;
  assign open_gate = !bl || sleeping;

  always_comb begin
    take_nmi = 1'b0;
    take_irl = 1'b0;
    take_mod = 1'b0;
    take_exc = 1'b0;
    take_mreset = 1'b0;
    if (boundary) begin
      if (nmi_live && (open_gate || ctrl_nmi_accept_r)) begin
        take_nmi = 1'b1;
      end else if (open_gate && (imask < encoded_irq_level)) begin
        take_irl = 1'b1;
      end else if (open_gate && mod_irq_req && (imask < mod_irq_level)) begin
        take_mod = 1'b1;
      end else if (exc_hit || user_break) begin
        if (bl && !user_break) begin
          take_mreset = 1'b1;
        end else begin
          take_exc = 1'b1;
        end
      end
    end
  end
  assign take_int = take_nmi || take_irl || take_mod;

  always_comb begin
    mod_code_clip = mod_irq_code;
    if (mod_irq_code < CODE_MOD_MIN) mod_code_clip = CODE_MOD_MIN;
    if (mod_irq_code > CODE_MOD_MAX) mod_code_clip = CODE_MOD_MAX;
    if (take_nmi) begin
      int_code = CODE_NMI;
    // Level code from level 15 down
    end else if (take_irl) begin
      int_code = CODE_IRL_BASE + CODE_IRL_STEP * {28'h0, ~encoded_irq_level};
    end else begin
      int_code = mod_code_clip;
    end
  end

  always_comb begin
    save_pc = in_branch_pair ? branch_dest : next_pc;
    if (take_exc && exc_reexec) begin
      // Faulting or slot PC
      // Slot PC only when a branch pair was offered
      save_pc = (exc_slot && in_branch_pair) ? slot_pc : cur_pc;
    end
  end

  // ----------------------------------------
  // Core state update
  // ----------------------------------------
  logic wr_fire;
  logic [ADDR_W-1:0] wr_addr_r;
  logic [DATA_W-1:0] wr_data_r;
  logic aw_held_r;
  logic w_held_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sr_r <= SR_RESET;
      saved_pc_r <= '0;
      saved_status_r <= '0;
      saved_r15_r <= '0;
      interrupt_event_code_r <= '0;
      exception_event_code_r <= '0;
      redirect_r <= 1'b0;
      redirect_pc_r <= RESET_PC;
      manual_reset_r <= 1'b0;
      pr_block_r <= 1'b0;
    end else begin
      redirect_r <= 1'b0;
      manual_reset_r <= 1'b0;
      pr_block_r <= 1'b0;
      if (take_int || take_exc) begin
        saved_pc_r <= save_pc;
        saved_status_r <= sr_r;
        saved_r15_r <= stack_gpr;
        sr_r[SR_BL] <= 1'b1;
        sr_r[SR_MD] <= 1'b1;
        sr_r[SR_RB] <= 1'b1;
        redirect_r <= 1'b1;
        if (take_int) begin
          interrupt_event_code_r <= int_code;
          redirect_pc_r <= vector_base_r + VEC_INTERRUPT;
        end else begin
          exception_event_code_r <= exc_code;
          redirect_pc_r <= vector_base_r + VEC_GENERAL;
          pr_block_r <= exc_reexec && exc_slot && in_branch_pair;
        end
      end else if (take_mreset) begin
        sr_r <= SR_RESET;
        exception_event_code_r <= CODE_MANUAL_RESET;
        redirect_r <= 1'b1;
        redirect_pc_r <= RESET_PC;
        manual_reset_r <= 1'b1;
      end else if (rte_exec) begin
        sr_r <= saved_status_r;
        redirect_r <= 1'b1;
        redirect_pc_r <= saved_pc_r;
      end else if (wr_fire && wr_addr_r == OFS_STATUS) begin
        sr_r <= wr_data_r;
      end else if (wr_fire && wr_addr_r == OFS_SPC) begin
        saved_pc_r <= wr_data_r;
      end else if (wr_fire && wr_addr_r == OFS_SSR) begin
        saved_status_r <= wr_data_r;
      end
    end
  end

  // NMI edge and pending hold
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nmi_prev_r <= 1'b0;
      nmi_pend_r <= 1'b0;
    end else begin
      nmi_prev_r <= nmi_pin;
      if (nmi_edge && !take_nmi) nmi_pend_r <= 1'b1;
      else if (take_nmi) nmi_pend_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // AXI4-Lite write
  // ----------------------------------------
  assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      wr_addr_r <= '0;
      wr_data_r <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      vector_base_r <= '0;
      ctrl_nmi_accept_r <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_held_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        wr_addr_r <= {s_axi_awaddr[ADDR_W-1:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wr_data_r <= s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
          {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
      end
      if (wr_fire) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_addr_r > OFS_EXCEPTION_EVENT_CODE) ? RESP_SLVERR : RESP_OKAY;
        if (wr_addr_r == OFS_CTRL) begin
          ctrl_nmi_accept_r <= wr_data_r[CTRL_NMI_BLOCK_ACCEPT];
        end
        if (wr_addr_r == OFS_VBR) vector_base_r <= wr_data_r;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // AXI4-Lite read
  // ----------------------------------------
  logic [DATA_W-1:0] rd_mux;
  logic rd_bad;

  always_comb begin
    rd_bad = 1'b0;
    unique case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
      OFS_CTRL: rd_mux = {31'h0, ctrl_nmi_accept_r};
      OFS_STATUS: rd_mux = sr_r;
      OFS_VBR: rd_mux = vector_base_r;
      OFS_SPC: rd_mux = saved_pc_r;
      OFS_SSR: rd_mux = saved_status_r;
      OFS_SGR: rd_mux = saved_r15_r;
      OFS_INTERRUPT_EVENT_CODE: rd_mux = interrupt_event_code_r;
      OFS_EXCEPTION_EVENT_CODE: rd_mux = exception_event_code_r;
      default: begin
        rd_mux = '0;
        rd_bad = 1'b1;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_bad ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign redirect = redirect_r;
  assign redirect_pc = redirect_pc_r;
  assign manual_reset = manual_reset_r;
  assign pr_write_block = pr_block_r;
  assign saved_r15 = saved_r15_r;
  assign status_word = sr_r;
endmodule

/* File: tb/cie_checker.sv */
// Purpose: port-level checks on interrupt and exception entry
// Assumes: bound to cie_top, one clock domain
// Notes: event codes held in registers are checked by the bench
module cie_checker
  import cie_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Requests
  input wire logic boundary,
  input wire logic sleeping,
  input wire logic nmi_pin,
  input wire logic [3:0] encoded_irq_level,
  input wire logic [31:0] stack_gpr,
  input wire logic [3:0] first_xfer,
  input wire logic user_break,
  input wire logic rte_exec,
  // Entry outputs
  input wire logic redirect,
  input wire logic [31:0] redirect_pc,
  input wire logic manual_reset,
  input wire logic pr_write_block,
  input wire logic [31:0] saved_r15,
  input wire logic [31:0] status_word
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // Triggers
  // ----------------------------------------
  sequence irl_s;
    boundary && !status_word[SR_BL] && (encoded_irq_level > status_word[7:4]);
  endsequence
  sequence nmi_s;
    boundary && !status_word[SR_BL] && $rose(nmi_pin);
  endsequence
  sequence exc_bl_s;
    boundary && status_word[SR_BL] && !sleeping && !nmi_pin && !user_break && (|first_xfer);
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  nmi_take_a:
    assert property (nmi_s |=> redirect) else $error("nmi edge not taken");
  irl_entry_a:
    assert property (irl_s |=> redirect && status_word[30:28] == 3'h7)
    else $error("level entry flags wrong");
  mask_keep_a:
    assert property (irl_s |=> status_word[7:4] == $past(status_word[7:4]))
    else $error("mask changed on entry");
  r15_save_a:
    assert property (irl_s |=> saved_r15 == $past(stack_gpr)) else $error("stack not saved");
  sleep_take_a:
    assert property (boundary && sleeping && encoded_irq_level > status_word[7:4] |=> redirect)
    else $error("sleep entry missed");
  mres_entry_a:
    assert property (exc_bl_s |=> manual_reset && status_word == SR_RESET
      && redirect_pc == RESET_PC) else $error("manual reset missing");
  mres_cause_a:
    assert property (manual_reset |-> $past(status_word[SR_BL])) else $error("stray manual reset");
  pr_block_a:
    assert property (pr_write_block |-> redirect) else $error("return write block alone");
  rte_ret_a:
    assert property (rte_exec && !boundary |=> redirect) else $error("return not taken");
endmodule

bind cie_top cie_checker u_cie_checker (.*);

/* File: tb/cie_pipe_model.sv */
// Purpose: pipeline model offering PCs and stack value
// Assumes: follows redirect, advances on each boundary
// Notes: never raises faults of its own
module cie_pipe_model
  import cie_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Boundary from bench, redirect from entry unit
  input wire logic boundary,
  input wire logic redirect,
  input wire logic [31:0] redirect_pc,
  // To entry unit
  output logic [31:0] cur_pc,
  output logic [31:0] next_pc,
  output logic [31:0] branch_dest,
  output logic [31:0] slot_pc,
  output logic [31:0] stack_gpr
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] pc_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_r <= 32'h00001000;
    end else if (redirect) begin
      pc_r <= redirect_pc;
    end else if (boundary) begin
      pc_r <= pc_r + 32'h4;
    end
  end
  assign cur_pc = pc_r;
  assign slot_pc = pc_r + 32'h2;
  assign next_pc = pc_r + 32'h4;
  assign branch_dest = pc_r + 32'h100;
  assign stack_gpr = ~pc_r;
endmodule

/* File: tb/cie_top_tb.sv */
// Purpose: directed tests of the entry unit
// Assumes: registers reached over AXI4-Lite
// Notes: one boundary per step, result seen one cycle later
module cie_top_tb
  import cie_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] VBR_V = 32'h8C000000;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, mod_irq_code = 32'h0, exc_code = 32'h000001A0;
  logic [3:0] s_axi_wstrb = 4'hF, encoded_irq_level = 4'h0, mod_irq_level = 4'h0;
  logic [3:0] first_xfer = 4'h0, second_xfer = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, nmi_pin = 1'b0, mod_irq_req = 1'b0;
  logic boundary = 1'b0, sleeping = 1'b0, in_branch_pair = 1'b0, user_break = 1'b0;
  logic rte_exec = 1'b0;
  logic [1:0] reexec_l12 = 2'h0, compl_l2 = 2'h0, lvl3 = 2'h0, lvl4 = 2'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, redirect_pc, saved_r15, status_word;
  logic redirect, manual_reset, pr_write_block;
  logic [31:0] cur_pc, next_pc, branch_dest, slot_pc, stack_gpr;
  logic [31:0] e_cur, e_next, e_slot, e_dest, e_r15;
  int err_count = 0, cmp_count = 0;

  cie_top u_cie_top (.*);
  cie_pipe_model u_cie_pipe_model (.*);

  always #12.5 aclk = ~aclk;

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic tally_and_finish();
    if (err_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 100);
    s_axi_bready <= 1'b0;
    chk({31'h0, s_axi_bvalid}, 32'h1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 100);
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, e);
  endtask

  // One boundary; expect {redirect, manual_reset, pr_write_block}
  task automatic bnd(input logic [2:0] e);
    logic [2:0] g;
    boundary <= 1'b1;
    @(posedge aclk);
    e_cur = cur_pc;
    e_next = next_pc;
    e_slot = slot_pc;
    e_dest = branch_dest;
    e_r15 = stack_gpr;
    boundary <= 1'b0;
    @(posedge aclk);
    g = {redirect, manual_reset, pr_write_block};
    if (e[1]) g[2] = e[2];
    chk({29'h0, g}, {29'h0, e});
  endtask

  task automatic exc(input logic p, input logic [1:0] rx, input logic [1:0] cp,
                     input logic [7:0] x, input logic [2:0] e);
    wr(OFS_STATUS, 32'h0);
    in_branch_pair <= p;
    reexec_l12 <= rx;
    compl_l2 <= cp;
    {second_xfer, first_xfer} <= x;
    bnd(e);
    in_branch_pair <= 1'b0;
    reexec_l12 <= 2'h0;
    compl_l2 <= 2'h0;
    {second_xfer, first_xfer} <= 8'h00;
    chk(redirect_pc, VBR_V + VEC_GENERAL);
    rd(OFS_EXCEPTION_EVENT_CODE, exc_code);
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFS_STATUS, SR_RESET);
    rd(8'h20, 32'h0);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    wr(OFS_VBR, VBR_V);
    rd(OFS_VBR, VBR_V);
    wr(OFS_STATUS, 32'h00000030);
    encoded_irq_level <= 4'h3;
    bnd(3'b000);
    encoded_irq_level <= 4'h6;
    bnd(3'b100);
    chk(redirect_pc, VBR_V + VEC_INTERRUPT);
    chk(saved_r15, e_r15);
    rd(OFS_INTERRUPT_EVENT_CODE, CODE_IRL_BASE + CODE_IRL_STEP * 9);
    rd(OFS_STATUS, 32'h70000030);
    rd(OFS_SPC, e_next);
    rd(OFS_SSR, 32'h00000030);
    rd(OFS_SGR, e_r15);
    bnd(3'b000);
    wr(OFS_STATUS, 32'h00000030);
    bnd(3'b100);
    sleeping <= 1'b1;
    bnd(3'b100);
    sleeping <= 1'b0;
    encoded_irq_level <= 4'h0;
    wr(OFS_STATUS, 32'h00000030);
    in_branch_pair <= 1'b1;
    mod_irq_req <= 1'b1;
    mod_irq_level <= 4'h4;
    mod_irq_code <= 32'h000005A0;
    bnd(3'b100);
    rd(OFS_INTERRUPT_EVENT_CODE, 32'h000005A0);
    rd(OFS_SPC, e_dest);
    mod_irq_req <= 1'b0;
    in_branch_pair <= 1'b0;
    wr(OFS_STATUS, 32'h000000F0);
    encoded_irq_level <= 4'hF;
    nmi_pin <= 1'b1;
    bnd(3'b100);
    rd(OFS_INTERRUPT_EVENT_CODE, CODE_NMI);
    nmi_pin <= 1'b0;
    rd(OFS_CTRL, 32'h0);
    nmi_pin <= 1'b1;
    bnd(3'b000);
    wr(OFS_CTRL, 32'h1);
    bnd(3'b100);
    rd(OFS_INTERRUPT_EVENT_CODE, CODE_NMI);
    nmi_pin <= 1'b0;
    encoded_irq_level <= 4'h0;
    wr(OFS_CTRL, 32'h0);
    rd(OFS_SSR, 32'h700000F0);
    rte_exec <= 1'b1;
    @(posedge aclk);
    rte_exec <= 1'b0;
    @(posedge aclk);
    chk({31'h0, redirect}, 32'h1);
    chk(redirect_pc, e_next);
    chk(status_word, 32'h700000F0);
    exc(1'b1, 2'b10, 2'b01, 8'h00, 3'b101);
    rd(OFS_SPC, e_slot);
    exc(1'b1, 2'b00, 2'b01, 8'h00, 3'b100);
    rd(OFS_SPC, e_dest);
    exc(1'b0, 2'b00, 2'b00, 8'h18, 3'b100);
    rd(OFS_SPC, e_cur);
    exc(1'b1, 2'b00, 2'b00, 8'h10, 3'b101);
    rd(OFS_SPC, e_slot);
    first_xfer <= 4'h1;
    bnd(3'b010);
    first_xfer <= 4'h0;
    chk(status_word, SR_RESET);
    chk(redirect_pc, RESET_PC);
    rd(OFS_EXCEPTION_EVENT_CODE, CODE_MANUAL_RESET);
    tally_and_finish();
  end

  initial begin
    repeat (5000) @(posedge aclk);
    err_count++;
    tally_and_finish();
  end
endmodule
